//--- design/fpsc_pkg.sv
// Shared constants and carrier types for the flash programming and security controller.
`default_nettype none
package fpsc_pkg;
  // ----------------------------------------------------------------
  // Flash array geometry
  // ----------------------------------------------------------------
  localparam int         FLASH_BYTES = 64;
  localparam int         ADDR_W      = 6;
  localparam logic [7:0] BLANK_BYTE  = 8'hFF;
  localparam logic [3:0] BLK_FIRST   = 4'h0;
  localparam logic [3:0] BLK_LAST    = 4'hF;
  localparam logic [5:0] ADDR_FIRST  = 6'h00;
  localparam logic [5:0] ADDR_LAST   = 6'h3F;

  // ----------------------------------------------------------------
  // Programmer commands and security bits
  // ----------------------------------------------------------------
  localparam logic [2:0] CMD_CHIP_ERASE  = 3'h1;
  localparam logic [2:0] CMD_BLOCK_ERASE = 3'h2;
  localparam logic [2:0] CMD_WRITE       = 3'h3;
  localparam logic [2:0] CMD_CHECKSUM    = 3'h4;
  localparam logic [2:0] CMD_BLANK_CHECK = 3'h5;
  localparam logic [2:0] CMD_SECURITY    = 3'h6;
  localparam int         SEC_CHIP        = 0;
  localparam int         SEC_BLOCK       = 1;
  localparam int         SEC_WRITE       = 2;
  localparam logic [2:0] SEC_RESET       = 3'h0;

  // ----------------------------------------------------------------
  // Register map and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_KEY     = 8'h00;
  localparam logic [7:0] REG_MODE    = 8'h04;
  localparam logic [7:0] REG_SP_CMD  = 8'h08;
  localparam logic [7:0] REG_SP_ADDR = 8'h0C;
  localparam logic [7:0] REG_SP_DATA = 8'h10;
  localparam logic [7:0] REG_STATUS  = 8'h14;
  localparam logic [7:0] KEY_VALUE   = 8'hA5;
  localparam logic [7:0] BYTE_RESET  = 8'h00;

  typedef enum logic [1:0] {
    OP_ERASE = 2'h0,
    OP_WRITE = 2'h1,
    OP_CSUM  = 2'h2,
    OP_BLANK = 2'h3
  } fpsc_op_t;

  typedef struct packed {
    logic [2:0] cmd;
    logic [5:0] addr;
    logic [5:0] addr_end;
    logic [7:0] data;
  } fpsc_pg_cmd_t;

  typedef struct packed {
    fpsc_op_t   op;
    logic [5:0] lo;
    logic [5:0] hi;
    logic [7:0] data;
  } fpsc_eng_req_t;
endpackage
`default_nettype wire

//--- design/fpsc_flash_array.sv
// Flash array in flip-flops with its erase, write, checksum and blank check engine.
`timescale 1ns/1ps
`default_nettype none
module fpsc_flash_array
  import fpsc_pkg::*;
(
  input  wire logic          ref_clk,
  input  wire logic          rst,
  input  wire logic          start,
  input  wire fpsc_eng_req_t req,
  output logic               done,
  output logic               ok,
  output logic [7:0]         result,
  input  wire logic [5:0]    ld_addr,
  output logic [7:0]         ld_data
);
  typedef enum logic [2:0] {
    E_IDLE = 3'b001,
    E_RUN  = 3'b010,
    E_END  = 3'b100
  } fpsc_eng_st_t;

  fpsc_eng_st_t  state;
  fpsc_eng_req_t cur;
  logic [5:0]    idx;
  logic [7:0]    sum;
  logic          all_blank;
  logic [7:0]    mem [FLASH_BYTES];

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state <= E_IDLE;
      cur   <= '0;
      idx   <= ADDR_FIRST;
    end
    else
    begin
      case (state)
        E_IDLE:
        begin
          if (start)
          begin
            cur   <= req;
            idx   <= req.lo;
            state <= E_RUN;
          end
        end
        E_RUN:
        begin
          if (idx == cur.hi)
            state <= E_END;
          else
            idx <= idx + 6'd1;
        end
        E_END:   state <= E_IDLE;
        default: state <= E_IDLE;
      endcase
    end
  end

  // Programming can only clear bits, so a write over old data without an erase cannot
  // turn a zero back into a one and the verify then reports the mismatch.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < FLASH_BYTES; i++)
        mem[i] <= BLANK_BYTE;
    end
    else if (state == E_RUN && cur.op == OP_ERASE)
      mem[idx] <= BLANK_BYTE;
    else if (state == E_RUN && cur.op == OP_WRITE)
      mem[idx] <= mem[idx] & cur.data;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      sum       <= BYTE_RESET;
      all_blank <= 1'b1;
    end
    else if (state == E_IDLE)
    begin
      sum       <= BYTE_RESET;
      all_blank <= 1'b1;
    end
    else if (state == E_RUN)
    begin
      sum       <= sum + mem[idx];
      all_blank <= all_blank & (mem[idx] == BLANK_BYTE);
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      done    <= 1'b0;
      ok      <= 1'b0;
      result  <= BYTE_RESET;
      ld_data <= BYTE_RESET;
    end
    else
    begin
      done    <= (state == E_END);
      ld_data <= mem[ld_addr];
      if (state == E_END)
      begin
        case (cur.op)
          OP_WRITE: ok <= (mem[cur.hi] == cur.data);
          OP_BLANK: ok <= all_blank;
          default:  ok <= 1'b1;
        endcase
        result <= (cur.op == OP_CSUM) ? sum : BYTE_RESET;
      end
    end
  end
endmodule // fpsc_flash_array
`default_nettype wire

//--- design/fpsc_flash_program_security_ctrl.sv
// Top of the flash programming and security controller: link, security and self mode.
//
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Entering programming mode needs the programmer attached and a command from it.
// - Only the programmer starts commands; the device just answers each one.
// - Chip erase blanks the whole flash array.
// - Block erase blanks only the addressed block.
// - Write programs the data at the address, then verifies it.
// - Checksum sums the given address range and returns the sum.
// - Blank check reports whether the whole array is erased.
// - Every command gets an acknowledge, or a negative one if illegal.
// - Chip erase lock refuses both erases and locks every prohibition forever; rst still clears all three.
// - Writes stay allowed under chip erase lock; bits cannot return to one.
// - Block erase lock refuses block erase; chip erase clears it.
// - Write lock refuses write and block erase; chip erase clears it.
// - New security settings apply only from the next programming mode entry.
// - After reset all three prohibitions are clear.
// - Only the programmer sets prohibitions, in any combination.
// - Self programming ignores every security prohibition.
// - Self mode is entered only by the key write then a mode write.
// - A stop in self mode launches the set operation; completion ends it.
// - Maskable interrupts stay blocked throughout self programming mode.
// - Flash contents are readable through the load port.
// - An erased byte holds FFH.
module fpsc_flash_program_security_ctrl
  import fpsc_pkg::*;
(
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic              pready,
  output logic [31:0]       prdata,
  output logic              pslverr,
  input  wire logic         pg_attach,
  input  wire logic         pg_req,
  input  wire fpsc_pg_cmd_t pg_cmd,
  output logic              pg_rsp_valid,
  output logic              pg_rsp_ack,
  output logic [7:0]        pg_rsp_data,
  output logic              prog_mode,
  input  wire logic         cpu_halt_exec,
  output logic              cpu_stopped,
  output logic              int_block,
  input  wire logic [5:0]   ld_addr,
  output logic [7:0]        ld_data
);
  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_BUSY = 4'b0010,
    S_RESP = 4'b0100,
    S_SELF = 4'b1000
  } fpsc_state_t;

  localparam int SYNC_W = $bits(fpsc_pg_cmd_t) + 2;

  fpsc_state_t   state;
  logic [SYNC_W-1:0] sync1;
  logic [SYNC_W-1:0] sync2;
  fpsc_pg_cmd_t  cmd_s;
  logic          attach_s;
  logic          req_s;
  logic [2:0]    sec_nv;
  logic [2:0]    sec_act;
  logic          key_armed;
  logic          self_mode;
  logic [1:0]    sp_cmd;
  logic [5:0]    sp_addr;
  logic [7:0]    sp_data;
  logic [2:0]    cur_cmd;
  logic          pg_take;
  logic          self_take;
  logic          legal;
  logic          eng_start;
  fpsc_eng_req_t eng_req;
  logic          eng_done;
  logic          eng_ok;
  logic [7:0]    eng_result;
  logic          apb_wr;
  logic          apb_setup;

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  function automatic logic cmd_legal(input fpsc_pg_cmd_t c, input logic [2:0] sec);
    case (c.cmd)
      CMD_CHIP_ERASE:  return !sec[SEC_CHIP];
      CMD_BLOCK_ERASE: return !(sec[SEC_CHIP] | sec[SEC_BLOCK] | sec[SEC_WRITE]);
      CMD_WRITE:       return !sec[SEC_WRITE];
      CMD_CHECKSUM:    return c.addr <= c.addr_end;
      CMD_BLANK_CHECK: return 1'b1;
      CMD_SECURITY:    return 1'b1;
      default:         return 1'b0;
    endcase
  endfunction

  function automatic logic reg_mapped(input logic [7:0] a);
    return a == REG_KEY || a == REG_MODE || a == REG_SP_CMD ||
           a == REG_SP_ADDR || a == REG_SP_DATA || a == REG_STATUS;
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      sync1 <= '0;
      sync2 <= '0;
    end
    else
    begin
      sync1 <= {pg_attach, pg_req, pg_cmd};
      sync2 <= sync1;
    end
  end

  assign attach_s = sync2[SYNC_W-1];
  assign req_s    = sync2[SYNC_W-2];
  assign cmd_s    = sync2[SYNC_W-3:0];

  // ----------------------------------------------------------------
  // Programming mode and session security
  // ----------------------------------------------------------------
  // The session copy is taken only at entry, so a security set inside a session
  // changes nothing until the programmer detaches and enters again.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      prog_mode <= 1'b0;
      sec_act   <= SEC_RESET;
    end
    else if (!prog_mode && attach_s && req_s && state == S_IDLE && !self_mode)
    begin
      prog_mode <= 1'b1;
      sec_act   <= sec_nv;
    end
    else if (!attach_s && state == S_IDLE)
      prog_mode <= 1'b0;
  end

  assign pg_take   = state == S_IDLE && prog_mode && attach_s && req_s;
  assign self_take = state == S_IDLE && self_mode && !prog_mode && cpu_halt_exec;
  assign legal     = cmd_legal(cmd_s, sec_act);
  assign eng_start = (pg_take && legal && cmd_s.cmd != CMD_SECURITY) || self_take;

  always_comb
  begin
    eng_req      = '0;
    eng_req.data = cmd_s.data;
    eng_req.lo   = cmd_s.addr;
    eng_req.hi   = cmd_s.addr;
    if (self_take)
    begin
      eng_req.op   = fpsc_op_t'(sp_cmd);
      eng_req.data = sp_data;
      eng_req.lo   = sp_addr;
      eng_req.hi   = sp_addr;
      if (sp_cmd != OP_WRITE)
      begin
        eng_req.lo = {sp_addr[5:4], BLK_FIRST};
        eng_req.hi = {sp_addr[5:4], BLK_LAST};
      end
    end
    else
    begin
      case (cmd_s.cmd)
        CMD_CHIP_ERASE:
        begin
          eng_req.op = OP_ERASE;
          eng_req.lo = ADDR_FIRST;
          eng_req.hi = ADDR_LAST;
        end
        CMD_BLOCK_ERASE:
        begin
          eng_req.op = OP_ERASE;
          eng_req.lo = {cmd_s.addr[5:4], BLK_FIRST};
          eng_req.hi = {cmd_s.addr[5:4], BLK_LAST};
        end
        CMD_CHECKSUM:
        begin
          eng_req.op = OP_CSUM;
          eng_req.hi = cmd_s.addr_end;
        end
        CMD_BLANK_CHECK:
        begin
          eng_req.op = OP_BLANK;
          eng_req.lo = ADDR_FIRST;
          eng_req.hi = ADDR_LAST;
        end
        default: eng_req.op = OP_WRITE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Command sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state   <= S_IDLE;
      cur_cmd <= 3'h0;
    end
    else
    begin
      case (state)
        S_IDLE:
        begin
          cur_cmd <= cmd_s.cmd;
          if (self_take)
            state <= S_SELF;
          else if (pg_take)
            state <= eng_start ? S_BUSY : S_RESP;
        end
        S_BUSY:
          if (eng_done)
            state <= S_RESP;
        S_RESP:
          if (!req_s)
            state <= S_IDLE;
        S_SELF:
          if (eng_done)
            state <= S_IDLE;
        default: state <= S_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      pg_rsp_ack  <= 1'b0;
      pg_rsp_data <= BYTE_RESET;
    end
    else if (pg_take && !eng_start)
    begin
      pg_rsp_ack  <= legal;
      pg_rsp_data <= BYTE_RESET;
    end
    else if (state == S_BUSY && eng_done)
    begin
      pg_rsp_ack  <= eng_ok;
      pg_rsp_data <= eng_result;
    end
  end

  assign pg_rsp_valid = (state == S_RESP);
  assign cpu_stopped  = (state == S_SELF);
  assign int_block    = self_mode;

  // ----------------------------------------------------------------
  // Stored security prohibitions
  // ----------------------------------------------------------------
  // Clear as shipped
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      sec_nv <= SEC_RESET;
    else if (pg_take && legal && cmd_s.cmd == CMD_SECURITY)
    begin
      if (sec_nv[SEC_CHIP])
        sec_nv <= sec_nv | cmd_s.data[2:0];
      else
        sec_nv <= cmd_s.data[2:0];
    end
    else if (state == S_BUSY && eng_done && cur_cmd == CMD_CHIP_ERASE
             && !sec_nv[SEC_CHIP])
      sec_nv <= SEC_RESET;
  end

  // ----------------------------------------------------------------
  // APB slave and self programming registers
  // ----------------------------------------------------------------
  assign apb_wr    = psel && penable && pwrite;
  assign apb_setup = psel && !penable;
  assign pready    = 1'b1;
  assign pslverr   = psel && penable && !reg_mapped(paddr);

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      key_armed <= 1'b0;
      self_mode <= 1'b0;
    end
    else if (apb_wr)
    begin
      key_armed <= (paddr == REG_KEY) && (pwdata[7:0] == KEY_VALUE);
      if (paddr == REG_MODE && key_armed && state != S_SELF && !prog_mode)
        self_mode <= pwdata[0];
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      sp_cmd  <= OP_ERASE;
      sp_addr <= ADDR_FIRST;
      sp_data <= BLANK_BYTE;
    end
    else if (apb_wr && state != S_SELF)
    begin
      if (paddr == REG_SP_CMD)
        sp_cmd <= pwdata[1:0];
      if (paddr == REG_SP_ADDR)
        sp_addr <= pwdata[5:0];
      if (paddr == REG_SP_DATA)
        sp_data <= pwdata[7:0];
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      prdata <= 32'h0000_0000;
    else if (apb_setup && !pwrite)
    begin
      case (paddr)
        REG_MODE:    prdata <= {31'h0000_0000, self_mode};
        REG_SP_CMD:  prdata <= {30'h0000_0000, sp_cmd};
        REG_SP_ADDR: prdata <= {26'h000_0000, sp_addr};
        REG_SP_DATA: prdata <= {24'h00_0000, sp_data};
        REG_STATUS:  prdata <= {26'h000_0000, state != S_IDLE, self_mode,
                                prog_mode, sec_nv};
        default:     prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Flash array
  // ----------------------------------------------------------------
  // Self path bypasses security
  fpsc_flash_array u_array (
    .ref_clk (ref_clk),
    .rst     (rst),
    .start   (eng_start),
    .req     (eng_req),
    .done    (eng_done),
    .ok      (eng_ok),
    .result  (eng_result),
    .ld_addr (ld_addr),
    .ld_data (ld_data)
  );

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_CHIP_NAK: assert property (
    @(posedge ref_clk) disable iff (rst)
    pg_take && cmd_s.cmd == CMD_CHIP_ERASE && sec_act[SEC_CHIP]
    |=> state == S_RESP && !pg_rsp_ack)
    else $error("chip erase accepted under chip lock");

  AST_BLOCK_NAK: assert property (
    @(posedge ref_clk) disable iff (rst)
    pg_take && cmd_s.cmd == CMD_BLOCK_ERASE && (sec_act[SEC_BLOCK] || sec_act[SEC_WRITE])
    |=> state == S_RESP && !pg_rsp_ack)
    else $error("block erase accepted under lock");

  AST_WRITE_NAK: assert property (
    @(posedge ref_clk) disable iff (rst)
    pg_take && cmd_s.cmd == CMD_WRITE && sec_act[SEC_WRITE]
    |=> state == S_RESP && !pg_rsp_ack)
    else $error("write accepted under write lock");

  AST_CHIP_LOCK: assert property (
    @(posedge ref_clk) disable iff (rst)
    sec_nv[SEC_CHIP] |=> (sec_nv & $past(sec_nv)) == $past(sec_nv))
    else $error("prohibition cleared after chip lock");

  AST_SEC_SESSION: assert property (
    @(posedge ref_clk) disable iff (rst)
    prog_mode && $past(prog_mode) |-> $stable(sec_act))
    else $error("session security changed inside session");

  AST_MODE_ENTRY: assert property (
    @(posedge ref_clk) disable iff (rst)
    !prog_mode && !self_mode && attach_s && req_s && state == S_IDLE
    |=> prog_mode ##1 state != S_IDLE)
    else $error("programming mode not entered on command");

  AST_RESP_HOLD: assert property (
    @(posedge ref_clk) disable iff (rst)
    pg_rsp_valid && req_s |=> pg_rsp_valid && $stable(pg_rsp_ack))
    else $error("answer dropped while request stands");

  AST_SELF_LAUNCH: assert property (
    @(posedge ref_clk) disable iff (rst)
    self_take |=> cpu_stopped && int_block ##[1:80] !cpu_stopped)
    else $error("self operation did not launch and finish");
endmodule // fpsc_flash_program_security_ctrl
`default_nettype wire

//--- verification/fpsc_pgm.sv
// Behavioural flash programmer model that drives the command handshake pins.
`timescale 1ns/1ps
`default_nettype none
module fpsc_pgm
  import fpsc_pkg::*;
(
  input  wire logic       ref_clk,
  output logic            pg_attach,
  output logic            pg_req,
  output fpsc_pg_cmd_t    pg_cmd,
  input  wire logic       pg_rsp_valid,
  input  wire logic       pg_rsp_ack,
  input  wire logic [7:0] pg_rsp_data
);
  initial
  begin
    pg_attach = 1'b0;
    pg_req    = 1'b0;
    pg_cmd    = '0;
  end

  task automatic att(input logic v);
    @(posedge ref_clk);
    pg_attach <= v;
    repeat (4) @(posedge ref_clk);
  endtask

  // one command at a time
  // Waits as long as the device needs; only the bench watchdog ends a hang.
  task automatic send(input fpsc_pg_cmd_t c, output logic a, output logic [7:0] d);
    @(posedge ref_clk);
    pg_cmd <= c;
    @(posedge ref_clk);
    pg_req <= 1'b1;
    while (pg_rsp_valid !== 1'b1)
      @(posedge ref_clk);
    a = pg_rsp_ack;
    d = pg_rsp_data;
    pg_req <= 1'b0;
    while (pg_rsp_valid !== 1'b0)
      @(posedge ref_clk);
    // Released pins show the inverse so a late sampler picks up garbage.
    pg_cmd <= ~c;
  endtask
endmodule // fpsc_pgm
`default_nettype wire

//--- verification/tb_top.sv
// Testbench top: programmer sessions, security locks, APB and self programming.
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import fpsc_pkg::*;
;
  logic         ref_clk = 1'b0;
  logic         rst = 1'b1;
  logic         psel = 1'b0;
  logic         penable = 1'b0;
  logic         pwrite = 1'b0;
  logic         cpu_halt_exec = 1'b0;
  logic [7:0]   paddr = '0;
  logic [31:0]  pwdata = '0;
  logic [5:0]   ld_addr = '0;
  logic         pready, pslverr, pg_attach, pg_req, pg_rsp_valid, pg_rsp_ack;
  logic         prog_mode, cpu_stopped, int_block;
  logic [31:0]  prdata;
  logic [7:0]   pg_rsp_data, ld_data;
  logic [7:0]   mem [64];
  fpsc_pg_cmd_t pg_cmd;
  int           fails = 0;
  int           checks_done = 0;

  always #50 ref_clk = ~ref_clk;

  fpsc_flash_program_security_ctrl u_fpsc_flash_program_security_ctrl (.ref_clk, .rst,
    .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .pg_attach,
    .pg_req, .pg_cmd, .pg_rsp_valid, .pg_rsp_ack, .pg_rsp_data, .prog_mode,
    .cpu_halt_exec, .cpu_stopped, .int_block, .ld_addr, .ld_data);

  fpsc_pgm u_fpsc_pgm (.ref_clk, .pg_attach, .pg_req, .pg_cmd, .pg_rsp_valid,
    .pg_rsp_ack, .pg_rsp_data);

  task automatic test_done();
    if (fails == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic ck(input string nm, input logic [31:0] e, g);
    checks_done++;
    if (g !== e)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    @(posedge ref_clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1)
      @(posedge ref_clk);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic pg(input logic [2:0] c, input logic [5:0] a, e, input logic [7:0] d,
                    input logic ea, output logic [7:0] rd);
    logic k;
    u_fpsc_pgm.send(fpsc_pg_cmd_t'{c, a, e, d}, k, rd);
    ck("ack", {31'h0, ea}, {31'h0, k});
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] r;
    pg(CMD_WRITE, a, a, d, (mem[a] & d) === d, r);
    mem[a] = mem[a] & d;
  endtask

  task automatic ldck(input logic [5:0] a);
    @(posedge ref_clk);
    ld_addr <= a;
    repeat (3) @(posedge ref_clk);
    ck("ld_data", {24'h0, mem[a]}, {24'h0, ld_data});
  endtask

  task automatic reopen(input logic [2:0] sec);
    logic [31:0] r;
    logic        er;
    u_fpsc_pgm.att(1'b0);
    u_fpsc_pgm.att(1'b1);
    apb(1'b0, REG_STATUS, '0, r, er);
    ck("sec_nv", {29'h0, sec}, {29'h0, r[2:0]});
  endtask

  task automatic halt(input logic [1:0] op, input logic [5:0] a, input logic [7:0] d);
    int          n;
    logic [31:0] r;
    logic        er;
    apb(1'b1, REG_SP_CMD, {30'h0, op}, r, er);
    apb(1'b1, REG_SP_ADDR, {26'h0, a}, r, er);
    apb(1'b1, REG_SP_DATA, {24'h0, d}, r, er);
    @(posedge ref_clk);
    cpu_halt_exec <= 1'b1;
    @(posedge ref_clk);
    cpu_halt_exec <= 1'b0;
    for (n = 0; n < 4 && cpu_stopped !== 1'b1; n++)
      @(posedge ref_clk);
    ck("stopped", 32'h1, {31'h0, cpu_stopped});
    for (n = 0; n < 40 && cpu_stopped !== 1'b0; n++)
      @(posedge ref_clk);
    ck("stopped", 32'h0, {31'h0, cpu_stopped});
  endtask

  function automatic logic [7:0] csum(input int lo, hi);
    logic [7:0] s = 8'h00;
    for (int i = lo; i <= hi; i++)
      s += mem[i];
    return s;
  endfunction

  initial
  begin
    logic [31:0] r;
    logic [7:0]  r8;
    logic        er;
    void'($urandom(32'he30d_691d));
    foreach (mem[i])
      mem[i] = BLANK_BYTE;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    ck("prog_mode", 32'h0, {31'h0, prog_mode});
    apb(1'b0, REG_STATUS, '0, r, er);
    ck("sec_nv", {29'h0, SEC_RESET}, {29'h0, r[2:0]});
    apb(1'b1, 8'hFC, 32'h0000_0001, r, er);
    ck("pslverr", 32'h1, {31'h0, er});
    u_fpsc_pgm.att(1'b1);
    pg(CMD_BLANK_CHECK, '0, '0, '0, 1'b1, r8);
    ck("prog_mode", 32'h1, {31'h0, prog_mode});
    wr(ADDR_LAST, 8'h00);
    repeat (8)
    begin
      wr(6'($urandom), 8'($urandom));
      ldck(6'($urandom_range(63, 0)));
    end
    pg(CMD_CHECKSUM, ADDR_FIRST, ADDR_LAST, '0, 1'b1, r8);
    ck("csum", {24'h0, csum(0, 63)}, {24'h0, r8});
    pg(CMD_CHECKSUM, 6'h05, 6'h04, '0, 1'b0, r8);
    pg(CMD_BLANK_CHECK, '0, '0, '0, 1'b0, r8);
    pg(3'h0, '0, '0, '0, 1'b0, r8);
    pg(3'h7, '0, '0, '0, 1'b0, r8);
    pg(CMD_BLOCK_ERASE, 6'h30, 6'h30, '0, 1'b1, r8);
    for (int i = 48; i < 64; i++)
      mem[i] = BLANK_BYTE;
    pg(CMD_CHECKSUM, ADDR_FIRST, ADDR_LAST, '0, 1'b1, r8);
    ck("csum", {24'h0, csum(0, 63)}, {24'h0, r8});
    pg(CMD_SECURITY, '0, '0, 8'h06, 1'b1, r8);
    pg(CMD_BLOCK_ERASE, 6'h20, 6'h20, '0, 1'b1, r8);
    for (int i = 32; i < 48; i++)
      mem[i] = BLANK_BYTE;
    reopen(3'h6);
    pg(CMD_BLOCK_ERASE, 6'h20, 6'h20, '0, 1'b0, r8);
    pg(CMD_WRITE, 6'h21, 6'h21, 8'h55, 1'b0, r8);
    pg(CMD_CHIP_ERASE, '0, '0, '0, 1'b1, r8);
    foreach (mem[i])
      mem[i] = BLANK_BYTE;
    pg(CMD_BLANK_CHECK, '0, '0, '0, 1'b1, r8);
    reopen(3'h0);
    wr(6'h01, 8'h00);
    pg(CMD_SECURITY, '0, '0, 8'h01, 1'b1, r8);
    reopen(3'h1);
    pg(CMD_CHIP_ERASE, '0, '0, '0, 1'b0, r8);
    pg(CMD_BLOCK_ERASE, '0, '0, '0, 1'b0, r8);
    wr(6'h02, 8'h3C);
    wr(6'h01, 8'hFF);
    pg(CMD_SECURITY, '0, '0, 8'h00, 1'b1, r8);
    reopen(3'h1);
    u_fpsc_pgm.att(1'b0);
    apb(1'b1, REG_MODE, 32'h0000_0001, r, er);
    @(posedge ref_clk);
    ck("int_block", 32'h0, {31'h0, int_block});
    apb(1'b1, REG_KEY, {24'h0, KEY_VALUE}, r, er);
    apb(1'b1, REG_MODE, 32'h0000_0001, r, er);
    @(posedge ref_clk);
    ck("int_block", 32'h1, {31'h0, int_block});
    r8 = 8'($urandom);
    halt(OP_WRITE, 6'h3E, r8);
    mem[6'h3E] = r8;
    ldck(6'h3E);
    halt(OP_ERASE, 6'h00, 8'h00);
    for (int i = 0; i < 16; i++)
      mem[i] = BLANK_BYTE;
    ldck(6'h02);
    test_done();
  end

  initial
  begin
    repeat (30000) @(posedge ref_clk);
    fails++;
    test_done();
  end
endmodule // tb_top
`default_nettype wire
